// *** rtl/quadrature_and_revolution_input.sv ***
/*
  Position feedback input: quadrature counting, speed in rpm, revolution
  sensor stall watch, all behind an APB slave.
  Assumes encoder and sensor pins are already at logic levels and the
  step generator supplies its own step position.
*/
`timescale 1ns/10ps
// Contract
// - Every edge of both phases gives one count, four counts per period.
// - Counting keeps up with each phase at 200 kHz, 800,000 counts per second.
// - Counts per revolution is set by software and covers at least 24 to 1024.
// - Software selects the encoder as primary position sensor or as a slip monitor only; in monitor mode position reads step_pos and no slip check is made.
// - In primary mode the position reads directly in encoder counts.
// - In primary mode speed is computed in rpm from count rate and counts per revolution.
// - By default a low sensor level means active.
// - An unconnected sensor idles high and thus reads inactive by default.
// - A polarity setting makes a high sensor level the active one.
// - Revolution events serve stall detection and mark home refinement.
module quadrature_and_revolution_input #(
  parameter int SPEED_WINDOW_CYC = qri_pkg::SPEED_WINDOW_CYC,
  parameter int STALL_TIMEOUT_CYC = qri_pkg::STALL_TIMEOUT_CYC
) (
  input wire logic clk,                 // 40 MHz system clock
  input wire logic resetn,              // async reset, active low
  input wire logic psel,                // APB select
  input wire logic penable,             // APB access phase
  input wire logic pwrite,              // APB direction
  input wire logic [7:0] paddr,         // APB byte address
  input wire logic [31:0] pwdata,       // APB write data
  output logic [31:0] prdata,           // APB read data
  output logic pready,                  // APB ready
  output logic pslverr,                 // APB error, unmapped address
  input wire logic quad_phase_first,    // encoder first phase
  input wire logic quad_phase_second,   // encoder second phase
  input wire logic rev_in,              // revolution sensor pin
  input wire logic [31:0] step_pos,     // position in steps from step generator
  input wire logic motor_moving,        // motion in progress
  output logic home_mark,               // one pulse per sensor activation
  output logic stall_alarm              // stall detected, sticky
);
  pos_if pif ();

  quad_decoder u_dec (
    .clk(clk),
    .resetn(resetn),
    .q(pif.dec)
  );

  rev_sensor u_rev (
    .clk(clk),
    .resetn(resetn),
    .r(pif.rev)
  );

  logic [qri_pkg::CTRL_WIDTH-1:0] ctrl_reg;
  logic [qri_pkg::CPR_WIDTH-1:0] cpr_reg;
  logic [31:0] enc_pos_reg;
  logic [31:0] win_cnt_reg;
  logic [31:0] win_cycles_reg;
  logic [31:0] speed_reg;
  logic [31:0] num_reg;
  logic [16:0] rem_reg;
  logic [5:0] div_cnt_reg;
  logic div_busy_reg;
  logic phase_err_reg;
  logic stall_reg;
  logic dir_reg;
  logic [15:0] revcnt_reg;
  logic [31:0] stall_cnt_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic home_mark_reg;

  assign pif.raw_first = quad_phase_first;
  assign pif.raw_second = quad_phase_second;
  assign pif.raw_rev = rev_in;

  // control decode
  wire primary = ctrl_reg[qri_pkg::CTRL_PRIMARY_BIT];
  wire count_en = ctrl_reg[qri_pkg::CTRL_COUNT_EN_BIT];
  wire stall_en = ctrl_reg[qri_pkg::CTRL_STALL_EN_BIT];
  assign pif.rev_invert = ctrl_reg[qri_pkg::CTRL_REV_INV_BIT];

  // bus decode; zero-wait access, answer registered in the setup cycle
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_reg;
  wire wr = access & pwrite;
  wire sel_ctrl = paddr == qri_pkg::CTRL_OFS;
  wire sel_cpr = paddr == qri_pkg::CPR_OFS;
  wire sel_pos = paddr == qri_pkg::POS_OFS;
  wire sel_speed = paddr == qri_pkg::SPEED_OFS;
  wire sel_status = paddr == qri_pkg::STATUS_OFS;
  wire sel_revcnt = paddr == qri_pkg::REVCNT_OFS;
  wire mapped = sel_ctrl | sel_cpr | sel_pos | sel_speed | sel_status | sel_revcnt;
  wire wr_ctrl = wr & sel_ctrl;
  wire wr_cpr = wr & sel_cpr;
  wire wr_status = wr & sel_status;
  wire clear_pos = wr_ctrl & pwdata[qri_pkg::CTRL_CLEAR_BIT];

  // in monitor mode the reported position stays in motor steps
  wire [31:0] pos_view = primary ? enc_pos_reg : step_pos;
  wire [31:0] status_view = {28'h0000000, dir_reg, pif.rev_level, stall_reg, phase_err_reg};
  wire [31:0] rd_mux = sel_ctrl ? {28'h0000000, ctrl_reg} :
                       sel_cpr ? {16'h0000, cpr_reg} :
                       sel_pos ? pos_view :
                       sel_speed ? speed_reg :
                       sel_status ? status_view :
                       sel_revcnt ? {16'h0000, revcnt_reg} : 32'h00000000;

  // resolution below the customary floor is clamped, keeps the divider sane
  wire [15:0] cpr_eff = (cpr_reg < qri_pkg::CPR_MIN) ? qri_pkg::CPR_MIN : cpr_reg;

  // position count
  wire do_up = pif.step_up & count_en;
  wire do_dn = pif.step_dn & count_en;
  wire [31:0] pos_next = clear_pos ? 32'h00000000 :
                         do_up ? enc_pos_reg + 32'h00000001 :
                         do_dn ? enc_pos_reg - 32'h00000001 : enc_pos_reg;

  // speed window and rpm divider
  wire win_end = win_cycles_reg == 32'(SPEED_WINDOW_CYC - 1);
  // a pulse on the boundary cycle opens the next window instead of being lost
  wire [31:0] cnt_inc = {31'h00000000, do_up | do_dn};
  wire [31:0] win_cnt_next = win_end ? cnt_inc : win_cnt_reg + cnt_inc;
  wire [31:0] rpm_num = 32'(win_cnt_reg * qri_pkg::RPM_SCALE);
  wire [16:0] trial = {rem_reg[15:0], num_reg[31]};
  wire trial_ge = trial >= {1'b0, cpr_eff};
  wire [16:0] rem_next = trial_ge ? 17'(trial - {1'b0, cpr_eff}) : trial;
  wire div_last = div_busy_reg & (div_cnt_reg == 6'h1F);

  // stall watch: no activation for the timeout while moving
  wire stall_hit = stall_en & motor_moving & ~pif.rev_event &
                   (stall_cnt_reg == 32'(STALL_TIMEOUT_CYC - 1));
  wire [31:0] stall_cnt_next = (pif.rev_event | ~motor_moving | stall_hit) ? 32'h00000000 :
                               stall_cnt_reg + 32'h00000001;

  // sticky flags, hardware set wins over write-one-to-clear
  wire phase_err_next = pif.phase_err | (phase_err_reg & ~(wr_status & pwdata[qri_pkg::STAT_PHASE_ERR_BIT]));
  wire stall_next = stall_hit | (stall_reg & ~(wr_status & pwdata[qri_pkg::STAT_STALL_BIT]));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= qri_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata[qri_pkg::CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpr_reg <= qri_pkg::CPR_RESET;
    end else if (wr_cpr) begin
      cpr_reg <= pwdata[qri_pkg::CPR_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enc_pos_reg <= 32'h00000000;
    end else begin
      enc_pos_reg <= pos_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dir_reg <= 1'b0;
    end else if (do_up | do_dn) begin
      dir_reg <= do_up;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_err_reg <= 1'b0;
    end else begin
      phase_err_reg <= phase_err_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      win_cycles_reg <= 32'h00000000;
    end else begin
      win_cycles_reg <= win_end ? 32'h00000000 : win_cycles_reg + 32'h00000001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      win_cnt_reg <= 32'h00000000;
    end else begin
      win_cnt_reg <= win_cnt_next;
    end
  end

  // restoring divide, one quotient bit per clock; quotient replaces numerator
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      num_reg <= 32'h00000000;
      rem_reg <= 17'h00000;
    end else if (win_end) begin
      num_reg <= rpm_num;
      rem_reg <= 17'h00000;
    end else if (div_busy_reg) begin
      num_reg <= {num_reg[30:0], trial_ge};
      rem_reg <= rem_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_reg <= 6'h00;
      div_busy_reg <= 1'b0;
    end else if (win_end) begin
      div_cnt_reg <= 6'h00;
      div_busy_reg <= 1'b1;
    end else if (div_busy_reg) begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
      div_busy_reg <= ~div_last;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speed_reg <= 32'h00000000;
    end else if (!primary) begin
      speed_reg <= 32'h00000000;
    end else if (div_last) begin
      speed_reg <= {num_reg[30:0], trial_ge};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stall_cnt_reg <= 32'h00000000;
    end else begin
      stall_cnt_reg <= stall_cnt_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stall_reg <= 1'b0;
    end else begin
      stall_reg <= stall_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      revcnt_reg <= 16'h0000;
    end else begin
      revcnt_reg <= revcnt_reg + {15'h0000, pif.rev_event};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      home_mark_reg <= 1'b0;
    end else begin
      home_mark_reg <= pif.rev_event;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= setup & ~mapped;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign home_mark = home_mark_reg;
  assign stall_alarm = stall_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  count_up_a: assert property (do_up && !clear_pos |=> enc_pos_reg == $past(enc_pos_reg) + 32'h00000001)
    else $error("up count not applied");
  count_dn_a: assert property (do_dn && !clear_pos |=> enc_pos_reg == $past(enc_pos_reg) - 32'h00000001)
    else $error("down count not applied");
  cpr_floor_a: assert property (cpr_eff >= qri_pkg::CPR_MIN && (cpr_reg < qri_pkg::CPR_MIN || cpr_eff == cpr_reg))
    else $error("resolution not honoured");
  pos_primary_a: assert property (setup && !pwrite && sel_pos && primary |=> prdata == $past(enc_pos_reg))
    else $error("primary position not in counts");
  pos_monitor_a: assert property (setup && !pwrite && sel_pos && !primary |=> prdata == $past(step_pos))
    else $error("monitor position not in steps");
  speed_mode_a: assert property (!primary |=> speed_reg == 32'h00000000)
    else $error("speed reported outside primary mode");
  speed_done_a: assert property (win_end |-> ##[33:34] !div_busy_reg)
    else $error("rpm divide overran");
  stall_set_a: assert property (stall_hit |=> stall_alarm)
    else $error("stall timeout not flagged");
  home_pulse_a: assert property (pif.rev_event |=> home_mark ##1 !home_mark)
    else $error("home mark not a single pulse");
  cpr_write_a: assert property (wr_cpr |=> cpr_reg == $past(pwdata[qri_pkg::CPR_WIDTH-1:0]))
    else $error("resolution write lost");
  mode_write_a: assert property (wr_ctrl |=> primary == $past(pwdata[qri_pkg::CTRL_PRIMARY_BIT]))
    else $error("sensor mode write lost");
  pos_clear_a: assert property (clear_pos |=> enc_pos_reg == 32'h00000000)
    else $error("position clear not applied");
  dir_track_a: assert property (do_up |=> dir_reg)
    else $error("up count left direction down");
  phase_hold_a: assert property (phase_err_reg && !(wr_status && pwdata[qri_pkg::STAT_PHASE_ERR_BIT]) |=> phase_err_reg)
    else $error("phase error dropped uncleared");
  win_keep_a: assert property (win_end |=> win_cnt_reg == 32'($past(do_up | do_dn)))
    else $error("boundary count lost");
  rev_count_a: assert property (pif.rev_event |=> revcnt_reg == $past(revcnt_reg) + 16'h0001)
    else $error("activation not counted");
  stall_hold_a: assert property (stall_reg && !(wr_status && pwdata[qri_pkg::STAT_STALL_BIT]) |=> stall_reg)
    else $error("stall flag dropped uncleared");
  stall_idle_a: assert property (!motor_moving |=> stall_cnt_reg == 32'h00000000)
    else $error("stall timer ran while idle");

  up_seen_c: cover property (do_up ##[1:400] do_up);
  dn_seen_c: cover property (do_dn);
  rev_seen_c: cover property (pif.rev_event);
  stall_seen_c: cover property (stall_hit);
  clear_seen_c: cover property (clear_pos);
endmodule

// *** rtl/qri_pkg.sv ***
/*
  Constants for the quadrature and revolution input block: register map,
  field positions, reset values and timing figures.
  Assumes a 40 MHz system clock and a 32-bit APB register bus.
*/
package qri_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CPR_OFS = 8'h04;
  localparam logic [7:0] POS_OFS = 8'h08;
  localparam logic [7:0] SPEED_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] REVCNT_OFS = 8'h14;
  // control fields
  localparam int CTRL_PRIMARY_BIT = 0;
  localparam int CTRL_REV_INV_BIT = 1;
  localparam int CTRL_COUNT_EN_BIT = 2;
  localparam int CTRL_STALL_EN_BIT = 3;
  localparam int CTRL_CLEAR_BIT = 4;
  localparam int CTRL_WIDTH = 4;
  localparam logic [3:0] CTRL_RESET = 4'h4;
  // status fields
  localparam int STAT_PHASE_ERR_BIT = 0;
  localparam int STAT_STALL_BIT = 1;
  localparam int STAT_REV_LEVEL_BIT = 2;
  localparam int STAT_DIR_BIT = 3;
  // encoder resolution
  localparam int CPR_WIDTH = 16;
  localparam logic [15:0] CPR_RESET = 16'h0400;
  localparam logic [15:0] CPR_MIN = 16'h0018;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int SPEED_WINDOW_MS = 100;
  localparam int STALL_TIMEOUT_MS = 500;
  localparam logic [31:0] RPM_SCALE = 32'(60_000 / SPEED_WINDOW_MS);
  localparam int SPEED_WINDOW_CYC = CLK_HZ / 1000 * SPEED_WINDOW_MS;
  localparam int STALL_TIMEOUT_CYC = CLK_HZ / 1000 * STALL_TIMEOUT_MS;
endpackage

// *** rtl/pos_if.sv ***
/*
  Carrier between the top of the position input block and its decoder
  and revolution sensor conditioner.
  Assumes all three run on the same clock.
*/
`timescale 1ns/10ps
interface pos_if;
  logic raw_first;
  logic raw_second;
  logic raw_rev;
  logic rev_invert;
  logic step_up;
  logic step_dn;
  logic phase_err;
  logic rev_level;
  logic rev_event;
  modport dec (input raw_first, input raw_second, output step_up, output step_dn, output phase_err);
  modport rev (input raw_rev, input rev_invert, output rev_level, output rev_event);
  modport top (output raw_first, output raw_second, output raw_rev, output rev_invert,
               input step_up, input step_dn, input phase_err, input rev_level, input rev_event);
endinterface

// *** rtl/quad_decoder.sv ***
/*
  Four-times quadrature decoder: synchronises both phases, emits one
  count pulse per edge of either phase, flags a skipped state.
  Assumes phase edges at least three clocks apart.
*/
`timescale 1ns/10ps
module quad_decoder (
  input wire logic clk,     // system clock
  input wire logic resetn,  // async reset, active low
  pos_if.dec q              // phases in, count pulses out
);
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] prev_reg;
  logic up_reg;
  logic dn_reg;
  logic err_reg;
  logic [2:0] warm_reg;
  // history trusted only after three samples; the pins' first values
  // would otherwise compare against reset values and fake a move
  wire live = warm_reg[2];
  wire chg_first = sync2_reg[0] ^ prev_reg[0];
  wire chg_second = sync2_reg[1] ^ prev_reg[1];
  wire one_edge = live & (chg_first ^ chg_second);
  wire both_moved = live & chg_first & chg_second;
  wire phase_diff = sync2_reg[0] ^ sync2_reg[1];
  // first phase leading counts up
  wire up_next = one_edge & (chg_first ? phase_diff : ~phase_diff);
  wire dn_next = one_edge & ~up_next;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
      prev_reg <= 2'h3;
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      err_reg <= 1'b0;
      warm_reg <= 3'h0;
    end else begin
      warm_reg <= {warm_reg[1:0], 1'b1};
      sync1_reg <= {q.raw_second, q.raw_first};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      up_reg <= up_next;
      dn_reg <= dn_next;
      err_reg <= both_moved; // lost state, both moved at once
    end
  end

  assign q.step_up = up_reg;
  assign q.step_dn = dn_reg;
  assign q.phase_err = err_reg;

  x4_edge_a: assert property (@(posedge clk) disable iff (!resetn)
    one_edge |=> (up_reg ^ dn_reg)) else $error("phase edge produced no count");
  no_double_a: assert property (@(posedge clk) disable iff (!resetn)
    both_moved |=> (err_reg && !up_reg && !dn_reg)) else $error("skipped state counted");
endmodule

// *** rtl/rev_sensor.sv ***
/*
  Revolution sensor conditioner: synchronises the input, applies the
  selected polarity, pulses once per becoming active.
  Assumes the pin idles high when nothing is connected.
*/
`timescale 1ns/10ps
module rev_sensor (
  input wire logic clk,     // system clock
  input wire logic resetn,  // async reset, active low
  pos_if.rev r              // sensor pin in, level and event out
);
  logic sync1_reg;
  logic sync2_reg;
  logic level_reg;
  logic event_reg;
  // low is active unless inverted; idle high therefore reads inactive
  wire active = r.rev_invert ? sync2_reg : ~sync2_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      level_reg <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      sync1_reg <= r.raw_rev;
      sync2_reg <= sync1_reg;
      level_reg <= active;
      event_reg <= active & ~level_reg;
    end
  end

  assign r.rev_level = level_reg;
  assign r.rev_event = event_reg;

  rev_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    (!r.rev_invert && $past(r.rev_invert) == 1'b0 && sync2_reg) |=> !level_reg) else $error("idle high read as active");
  rev_invert_a: assert property (@(posedge clk) disable iff (!resetn)
    (r.rev_invert && sync2_reg) |=> level_reg) else $error("inverted high not active");
endmodule

// *** verification/enc_sensor_model.sv ***
/*
  Behavioural far side of the position input block: a quadrature encoder
  and an optical shaft revolution sensor, driven by tasks from the bench.
  Assumes the bench calls one task at a time and shares the system clock.
*/
`timescale 1ns/10ps
module enc_sensor_model (
  input wire logic clk,            // system clock, paces all pin changes
  output logic quad_phase_first,   // encoder phase one
  output logic quad_phase_second,  // encoder phase two
  output logic rev_in              // revolution sensor, pulled up when idle
);
  logic [1:0] pos_state;

  initial begin
    pos_state = 2'h0;
    quad_phase_first = 1'b0;
    quad_phase_second = 1'b0;
    rev_in = 1'b1; // pull-up holds an unconnected sensor high
  end

  // gray order 00,10,11,01 keeps the phases a quarter period apart
  function automatic logic [1:0] phases(input logic [1:0] s);
    case (s)
      2'h0: phases = 2'h0;
      2'h1: phases = 2'h2;
      2'h2: phases = 2'h3;
      default: phases = 2'h1;
    endcase
  endfunction

  // n edges, gap clocks apart; first phase leads when up is set
  task automatic move(input int n, input bit up, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge clk);
      pos_state = up ? pos_state + 2'h1 : pos_state - 2'h1;
      {quad_phase_first, quad_phase_second} <= phases(pos_state);
    end
  endtask

  // both phases flip together: the skipped state a broken encoder shows
  task automatic skip();
    @(posedge clk);
    pos_state = pos_state + 2'h2;
    {quad_phase_first, quad_phase_second} <= phases(pos_state);
  endtask

  // one sensor level change, held long enough to pass the synchroniser
  task automatic rev_level(input logic lvl);
    @(posedge clk);
    rev_in <= lvl;
    repeat (20) @(posedge clk);
  endtask
endmodule

// *** verification/quadrature_and_revolution_input_tb.sv ***
/*
  Self-checking bench for the position input block: APB register tasks,
  encoder and sensor stimulus through the partner model.
  Assumes short speed window and stall timeout parameters for run time.
*/
`timescale 1ns/10ps
module quadrature_and_revolution_input_tb;
  logic clk;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic quad_phase_first;
  logic quad_phase_second;
  logic rev_in;
  logic [31:0] step_pos = 32'h00012345;
  logic motor_moving = 1'b0;
  logic home_mark;
  logic stall_alarm;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int total_checks = 0;
  int marks = 0;
  logic [31:0] cprs [2] = '{32'h0000000A, 32'h00000030};
  logic [31:0] rpms [2] = '{32'h00000064, 32'h00000032};

  quadrature_and_revolution_input #(.SPEED_WINDOW_CYC(200), .STALL_TIMEOUT_CYC(100)) uut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .quad_phase_first(quad_phase_first), .quad_phase_second(quad_phase_second),
    .rev_in(rev_in), .step_pos(step_pos), .motor_moving(motor_moving),
    .home_mark(home_mark), .stall_alarm(stall_alarm));

  enc_sensor_model enc (.clk(clk), .quad_phase_first(quad_phase_first),
    .quad_phase_second(quad_phase_second), .rev_in(rev_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (home_mark === 1'b1) marks <= marks + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk("pready", 32'h00000001, 32'h00000000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(what, exp, rd & m);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rchk("ctrl", qri_pkg::CTRL_OFS, 32'hFFFFFFFF, 32'h00000004);
    rchk("cpr", qri_pkg::CPR_OFS, 32'hFFFFFFFF, 32'h00000400);
    rchk("pos_monitor", qri_pkg::POS_OFS, 32'hFFFFFFFF, 32'h00012345);
    rchk("speed_monitor", qri_pkg::SPEED_OFS, 32'hFFFFFFFF, 32'h00000000);
    rchk("status", qri_pkg::STATUS_OFS, 32'hFFFFFFFF, 32'h00000000);
    rchk("revcnt", qri_pkg::REVCNT_OFS, 32'hFFFFFFFF, 32'h00000000);
    xfer(1'b0, 8'h3C, 32'h00000000);
    chk("unmapped_err", 32'h00000001, {31'h0, err});
    chk("unmapped_data", 32'h00000000, rd);
    $display("test reset_values done");
    // invert switched while the pin is low, so no spurious activation
    enc.rev_level(1'b0);
    rchk("rev_active_low", qri_pkg::STATUS_OFS, 32'h4, 32'h4);
    xfer(1'b1, qri_pkg::CTRL_OFS, 32'h00000006);
    rchk("rev_inactive_inv", qri_pkg::STATUS_OFS, 32'h4, 32'h0);
    enc.rev_level(1'b1);
    rchk("rev_active_inv", qri_pkg::STATUS_OFS, 32'h4, 32'h4);
    enc.rev_level(1'b0);
    rchk("revcnt", qri_pkg::REVCNT_OFS, 32'h0000FFFF, 32'h00000002);
    chk("home_marks", 32'h00000002, 32'(marks));
    $display("test rev_sensor done");
    xfer(1'b1, qri_pkg::CTRL_OFS, 32'h00000015);
    rchk("pos_cleared", qri_pkg::POS_OFS, 32'hFFFFFFFF, 32'h00000000);
    enc.move(8, 1'b1, 50);
    repeat (8) @(posedge clk);
    rchk("pos_up", qri_pkg::POS_OFS, 32'hFFFFFFFF, 32'h00000008);
    rchk("dir_up", qri_pkg::STATUS_OFS, 32'h8, 32'h8);
    enc.move(3, 1'b0, 3);
    repeat (8) @(posedge clk);
    rchk("pos_down", qri_pkg::POS_OFS, 32'hFFFFFFFF, 32'h00000005);
    rchk("dir_down", qri_pkg::STATUS_OFS, 32'h8, 32'h0);
    // count enable off: edges must leave the position alone
    xfer(1'b1, qri_pkg::CTRL_OFS, 32'h00000001);
    enc.move(4, 1'b1, 3);
    repeat (8) @(posedge clk);
    rchk("pos_hold", qri_pkg::POS_OFS, 32'hFFFFFFFF, 32'h00000005);
    xfer(1'b1, qri_pkg::CTRL_OFS, 32'h00000005);
    $display("test position done");
    // 4 edges per 200-clock window: rpm = 4*600/cpr, cpr below 24 taken as 24
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, qri_pkg::CPR_OFS, cprs[k]);
      fork
        enc.move(40, 1'b1, 50);
        begin
          repeat (1000) @(posedge clk);
          rchk("speed_rpm", qri_pkg::SPEED_OFS, 32'hFFFFFFFF, rpms[k]);
        end
      join
    end
    $display("test speed done");
    enc.skip();
    repeat (8) @(posedge clk);
    rchk("phase_err", qri_pkg::STATUS_OFS, 32'h1, 32'h1);
    xfer(1'b1, qri_pkg::STATUS_OFS, 32'h00000001);
    rchk("phase_err_clr", qri_pkg::STATUS_OFS, 32'h1, 32'h0);
    $display("test phase_error done");
    xfer(1'b1, qri_pkg::CTRL_OFS, 32'h0000000D);
    motor_moving <= 1'b1;
    repeat (150) @(posedge clk);
    chk("stall_alarm", 32'h00000001, {31'h0, stall_alarm});
    rchk("stall_status", qri_pkg::STATUS_OFS, 32'h2, 32'h2);
    motor_moving <= 1'b0;
    xfer(1'b1, qri_pkg::STATUS_OFS, 32'h00000002);
    rchk("stall_clr", qri_pkg::STATUS_OFS, 32'h2, 32'h0);
    $display("test stall done");
    close_out();
  end
endmodule
